//--- logic/uib_pkg.sv
// Shared constants for the UART interrupt and baud generator block
package uib_pkg;
   // Six-bit identification codes
   localparam logic [5:0] ID_NONE    = 6'h01;
   localparam logic [5:0] ID_LINE    = 6'h06;
   localparam logic [5:0] ID_TIMEOUT = 6'h0C;
   localparam logic [5:0] ID_RXDATA  = 6'h04;
   localparam logic [5:0] ID_TX      = 6'h02;
   localparam logic [5:0] ID_MODEM   = 6'h08;
   localparam logic [5:0] ID_FLOWOFF = 6'h10;
   localparam logic [5:0] ID_HSHAKE  = 6'h20;
   // Source enable bit positions
   localparam int EN_RX    = 0;
   localparam int EN_TX    = 1;
   localparam int EN_LINE  = 2;
   localparam int EN_MODEM = 3;
   localparam int EN_FLOW  = 5;
   localparam int EN_HS    = 6;
   localparam int EN_HS2   = 7;
   // Control bit positions
   localparam int LCR_BREAK  = 6;
   localparam int DLF_OVS8   = 7;
   localparam int MCR_PRE4   = 7;
   // Timeout: 4 x word length + 12 bit times
   localparam int TO_MULT    = 4;
   localparam int TO_EXTRA   = 12;
   // Oversampling ratios, prescale and fraction width
   localparam int OVS_16     = 16;
   localparam int OVS_8      = 8;
   localparam logic [1:0] PRE_LAST = 2'h3;
   localparam int FRAC_BITS  = 6;
endpackage

//--- logic/uib_baud_gen.sv
// Fractional baud generator with optional divide-by-4 prescaler
`timescale 1ns/10ps
module uib_baud_gen #(
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Settings
   input  wire logic [DIV_W-1:0] divisor,
   input  wire logic [5:0]       frac,
   input  wire logic             pre4,
   // Oversample tick
   output logic                  tick
);
   logic [1:0]       pre_q, pre_d;
   logic [DIV_W-1:0] cnt_q, cnt_d;
   logic [5:0]       acc_q, acc_d;
   logic             tick_q, tick_d;
   logic             pre_en;
   logic [6:0]       acc_sum;

   assign tick = tick_q;
   assign acc_sum = {1'b0, acc_q} + {1'b0, frac};

   always_comb
   begin
      pre_d  = pre_q;
      cnt_d  = cnt_q;
      acc_d  = acc_q;
      tick_d = 1'b0;
      // Prescaler ahead of divisor
      pre_en = pre4 ? (pre_q == uib_pkg::PRE_LAST) : 1'b1;
      if (pre4)
         pre_d = pre_q + 2'h1;
      else
         pre_d = 2'h0;
      if (divisor == '0)
      begin
         cnt_d = '0;
         acc_d = '0;
      end
      else if (pre_en)
      begin
         // Fraction carry stretches one period by a cycle
         if (cnt_q == '0)
         begin
            tick_d = 1'b1;
            acc_d  = acc_sum[5:0];
            cnt_d  = divisor - (acc_sum[6] ? '0 : {{(DIV_W-1){1'b0}}, 1'b1});
         end
         else
            cnt_d = cnt_q - {{(DIV_W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pre_q  <= 2'h0;
         cnt_q  <= '0;
         acc_q  <= 6'h00;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q  <= pre_d;
         cnt_q  <= cnt_d;
         acc_q  <= acc_d;
         tick_q <= tick_d;
      end
   end
endmodule

//--- logic/uib_top.sv
// Interrupt prioritiser, RX timeout, break and baud clock of a UART
`timescale 1ns/10ps
module uib_top #(
   parameter int DIV_W = 16,
   parameter int TO_W  = 10
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             nrst,
   // Configuration
   input  wire logic [7:0]       source_enable_reg,
   input  wire logic [7:0]       line_control_reg,
   input  wire logic [7:0]       modem_control_reg,
   input  wire logic [7:0]       divisor_low_byte,
   input  wire logic [7:0]       divisor_high_byte,
   input  wire logic [7:0]       divisor_fraction_reg,
   input  wire logic             fifo_enable,
   // Receive FIFO status
   input  wire logic             rx_fifo_nonempty,
   input  wire logic             rx_data_available,
   input  wire logic             rx_above_trigger,
   input  wire logic             rx_fifo_error_any,
   input  wire logic             head_framing_flag,
   input  wire logic             head_parity_flag,
   input  wire logic             head_break_flag,
   input  wire logic             overrun_event,
   input  wire logic             rx_char_event,
   // Transmit status
   input  wire logic             tx_holding_empty,
   input  wire logic             tx_passed_trigger,
   input  wire logic             tx_serial_in,
   // Flow and modem events
   input  wire logic             flow_off_event,
   input  wire logic             special_char_event,
   input  wire logic             flow_on_event,
   input  wire logic [3:0]       modem_change_flags,
   input  wire logic             rts_pin,
   input  wire logic             cts_pin,
   // Serial receive line
   input  wire logic             rx_line,
   // Host access strobes
   input  wire logic             receive_holding_read,
   input  wire logic             transmit_holding_write,
   input  wire logic             ident_read,
   input  wire logic             line_state_read,
   input  wire logic             modem_state_read,
   // Results
   output logic                  irq,
   output logic [5:0]            pending_source_id_reg,
   output logic [2:0]            line_err_flags,
   output logic                  line_err_summary,
   output logic                  line_overrun,
   output logic                  timeout_pending,
   output logic                  tx_serial_out,
   output logic                  baud_tick
);
   logic             ovr_q, ovr_d;
   logic             to_q, to_d;
   logic             thr_q, thr_d;
   logic             flow_q, flow_d;
   logic             flow_spec_q, flow_spec_d;
   logic             hs_q, hs_d;
   logic             rts_q, cts_q;
   logic [TO_W-1:0]  idle_q, idle_d;
   logic [TO_W-1:0]  to_limit;
   logic [3:0]       wlen;
   logic [5:0]       id_d, id_q;
   logic [2:0]       err_d, err_q;
   logic             irq_d, irq_q;
   logic             tx_src;
   logic             tick;
   logic [4:0]       ovs_n;
   logic [4:0]       ovs_q, ovs_d;
   logic             bit_tick;
   logic [7:0]       en;

   assign en = source_enable_reg;

   // One generator shared by both directions
   uib_baud_gen #(.DIV_W(DIV_W)) u_baud (
      .clk     (clk),
      .nrst    (nrst),
      .divisor ({divisor_high_byte, divisor_low_byte}),
      .frac    (divisor_fraction_reg[uib_pkg::FRAC_BITS-1:0]),
      .pre4    (modem_control_reg[uib_pkg::MCR_PRE4]),
      .tick    (tick)
   );
   assign baud_tick = tick;

   // Bit time from oversample ticks
   always_comb
   begin
      ovs_n = divisor_fraction_reg[uib_pkg::DLF_OVS8]
            ? 5'(uib_pkg::OVS_8 - 1) : 5'(uib_pkg::OVS_16 - 1);
      ovs_d = ovs_q;
      bit_tick = 1'b0;
      if (tick)
      begin
         if (ovs_q >= ovs_n)
         begin
            ovs_d = 5'h00;
            bit_tick = 1'b1;
         end
         else
            ovs_d = ovs_q + 5'h01;
      end
   end

   // Timeout counter
   always_comb
   begin
      wlen = 4'h5 + {2'h0, line_control_reg[1:0]};
      to_limit = TO_W'(uib_pkg::TO_MULT) * TO_W'(wlen)
               + TO_W'(uib_pkg::TO_EXTRA);
      idle_d = idle_q;
      to_d = to_q;
      // Any receive activity restarts the stale-data timer
      if (!rx_line || !rx_fifo_nonempty || rx_char_event
          || receive_holding_read)
         idle_d = '0;
      else if (bit_tick && idle_q < to_limit)
         idle_d = idle_q + {{(TO_W-1){1'b0}}, 1'b1};
      if (receive_holding_read || !rx_fifo_nonempty)
         to_d = 1'b0;
      if (rx_fifo_nonempty && rx_line && bit_tick
          && idle_q == to_limit - {{(TO_W-1){1'b0}}, 1'b1})
         to_d = 1'b1;
   end

   // Sticky event flags; a set in the clearing cycle wins, except transmit_holding_write blocks the transmit set
   always_comb
   begin
      tx_src = fifo_enable ? tx_passed_trigger : tx_holding_empty;
      ovr_d = ovr_q;
      if (line_state_read)
         ovr_d = 1'b0;
      if (overrun_event)
         ovr_d = 1'b1;
      thr_d = thr_q;
      if (ident_read || transmit_holding_write)
         thr_d = 1'b0;
      if (tx_src && !transmit_holding_write)
         thr_d = 1'b1;
      flow_d = flow_q;
      flow_spec_d = flow_spec_q;
      if (flow_on_event && !flow_spec_q)
         flow_d = 1'b0;
      if (ident_read && flow_spec_q)
      begin
         flow_d = 1'b0;
         flow_spec_d = 1'b0;
      end
      if (special_char_event)
      begin
         flow_d = 1'b1;
         flow_spec_d = 1'b1;
      end
      if (flow_off_event)
      begin
         flow_d = 1'b1;
         flow_spec_d = 1'b0;
      end
      hs_d = hs_q;
      if (ident_read)
         hs_d = 1'b0;
      if ((rts_pin && !rts_q) || (cts_pin && !cts_q))
         hs_d = 1'b1;
   end

   // Head flags and priority encoder
   always_comb
   begin
      err_d = rx_fifo_nonempty
            ? {head_break_flag, head_framing_flag, head_parity_flag}
            : 3'h0;
      id_d = uib_pkg::ID_NONE;
      if (en[uib_pkg::EN_HS] && en[uib_pkg::EN_HS2] && hs_q)
         id_d = uib_pkg::ID_HSHAKE;
      if (en[uib_pkg::EN_FLOW] && flow_q)
         id_d = uib_pkg::ID_FLOWOFF;
      if (en[uib_pkg::EN_MODEM] && modem_change_flags != 4'h0)
         id_d = uib_pkg::ID_MODEM;
      if (en[uib_pkg::EN_TX] && thr_q)
         id_d = uib_pkg::ID_TX;
      if (en[uib_pkg::EN_RX]
          && (fifo_enable ? rx_above_trigger : rx_data_available))
         id_d = uib_pkg::ID_RXDATA;
      if (en[uib_pkg::EN_RX] && to_q)
         id_d = uib_pkg::ID_TIMEOUT;
      if (en[uib_pkg::EN_LINE] && (rx_fifo_error_any || ovr_q))
         id_d = uib_pkg::ID_LINE;
      // All-zero low enables leave host polling line status
      irq_d = id_d != uib_pkg::ID_NONE;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ovr_q       <= 1'b0;
         to_q        <= 1'b0;
         thr_q       <= 1'b0;
         flow_q      <= 1'b0;
         flow_spec_q <= 1'b0;
         hs_q        <= 1'b0;
         rts_q       <= 1'b1;
         cts_q       <= 1'b1;
         idle_q      <= '0;
         ovs_q       <= 5'h00;
         id_q        <= uib_pkg::ID_NONE;
         err_q       <= 3'h0;
         irq_q       <= 1'b0;
      end
      else
      begin
         ovr_q       <= ovr_d;
         to_q        <= to_d;
         thr_q       <= thr_d;
         flow_q      <= flow_d;
         flow_spec_q <= flow_spec_d;
         hs_q        <= hs_d;
         rts_q       <= rts_pin;
         cts_q       <= cts_pin;
         idle_q      <= idle_d;
         ovs_q       <= ovs_d;
         id_q        <= id_d;
         err_q       <= err_d;
         irq_q       <= irq_d;
      end
   end

   assign irq                   = irq_q;
   assign pending_source_id_reg = id_q;
   assign line_err_flags        = err_q;
   assign line_err_summary      = rx_fifo_error_any;
   assign line_overrun          = ovr_q;
   assign timeout_pending       = to_q;
   // Break forces line low regardless of serialiser
   assign tx_serial_out = tx_serial_in
                        & ~line_control_reg[uib_pkg::LCR_BREAK];
endmodule

//--- tb/uib_top_assertions.sv
// Port-level checker for the UART interrupt and baud block
`timescale 1ns/10ps
module uib_top_chk #(
   parameter int DIV_W = 16,
   parameter int TO_W  = 10
) (
   // Clock and reset
   input wire logic       clk,
   input wire logic       nrst,
   // Inputs watched
   input wire logic [7:0] source_enable_reg,
   input wire logic [7:0] line_control_reg,
   input wire logic [7:0] divisor_low_byte,
   input wire logic [7:0] divisor_high_byte,
   input wire logic       rx_fifo_nonempty,
   input wire logic       rx_fifo_error_any,
   input wire logic       overrun_event,
   input wire logic       tx_serial_in,
   // Outputs watched
   input wire logic       irq,
   input wire logic [5:0] pending_source_id_reg,
   input wire logic [2:0] line_err_flags,
   input wire logic       line_err_summary,
   input wire logic       line_overrun,
   input wire logic       timeout_pending,
   input wire logic       tx_serial_out,
   input wire logic       baud_tick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_break_low: assert property (line_control_reg[6] |-> !tx_serial_out)
      else $error("transmit line not held low during break");
   chk_tx_pass: assert property (!line_control_reg[6]
      |-> tx_serial_out == tx_serial_in)
      else $error("transmit line does not follow serialiser");
   chk_summary_follow: assert property (
      line_err_summary == rx_fifo_error_any)
      else $error("summary error flag differs from fifo error");
   chk_flags_empty: assert property (!rx_fifo_nonempty [*2]
      |-> line_err_flags == 3'h0)
      else $error("per character flags set with empty fifo");
   chk_zero_div: assert property (
      ({divisor_high_byte, divisor_low_byte} == 16'h0000) [*3]
      |-> !baud_tick)
      else $error("baud tick with zero divisor");
   chk_line_first: assert property (
      (source_enable_reg[2] && rx_fifo_error_any) [*2]
      |-> pending_source_id_reg == uib_pkg::ID_LINE)
      else $error("line status not reported first");
   chk_irq_code: assert property (
      irq == (pending_source_id_reg != uib_pkg::ID_NONE))
      else $error("interrupt output disagrees with code");
   chk_all_off: assert property ((source_enable_reg == 8'h00) [*2]
      |-> !irq && pending_source_id_reg == uib_pkg::ID_NONE)
      else $error("interrupt with all sources disabled");
   chk_flow_gate: assert property (!source_enable_reg[5] [*2]
      |-> pending_source_id_reg != uib_pkg::ID_FLOWOFF)
      else $error("flow-off shown while disabled");
   chk_overrun_set: assert property (overrun_event |=> line_overrun)
      else $error("overrun not captured");
   cover property (irq);
   cover property (timeout_pending);
   cover property (line_control_reg[6] && tx_serial_in);
endmodule
bind uib_top uib_top_chk #(.DIV_W(DIV_W), .TO_W(TO_W)) u_chk (.*);

//--- tb/uib_line_model.sv
// Far-side serial line source feeding the receive input
`timescale 1ns/10ps
module uib_line_model (
   // Clock
   input  wire logic clk,
   // Control
   input  wire logic idle_high,
   // Line
   output logic      rx_line
);
   logic tog_q = 1'b0;
   // Busy line changes every cycle so no stale level lingers
   always_ff @(posedge clk) tog_q <= ~tog_q;
   assign rx_line = idle_high | tog_q;
endmodule

//--- tb/uib_top_tb.sv
// Self-checking testbench for the UART interrupt and baud block
`timescale 1ns/10ps
module uib_top_tb;
   logic [7:0] source_enable_reg, line_control_reg, modem_control_reg;
   logic [7:0] divisor_low_byte, divisor_high_byte, divisor_fraction_reg;
   logic [3:0] modem_change_flags;
   logic [5:0] pending_source_id_reg;
   logic [2:0] line_err_flags;
   logic       clk, nrst, fifo_enable, rx_fifo_nonempty, rx_data_available;
   logic       rx_above_trigger, rx_fifo_error_any, head_framing_flag;
   logic       head_parity_flag, head_break_flag, overrun_event;
   logic       rx_char_event, tx_holding_empty, tx_passed_trigger;
   logic       tx_serial_in, flow_off_event, special_char_event;
   logic       flow_on_event, rts_pin, cts_pin, rx_line, line_idle;
   logic       receive_holding_read, transmit_holding_write, ident_read;
   logic       line_state_read, modem_state_read, irq, line_err_summary;
   logic       line_overrun, timeout_pending, tx_serial_out, baud_tick;
   logic [5:0] q[$];
   event       smp;
   int         err_count, checks, tn, p, p2, d, n;
   logic [2:0] r;
   uib_top dut (.*);
   uib_line_model m (.clk(clk), .idle_high(line_idle), .rx_line(rx_line));
   always #4 clk = ~clk;
   task step(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
      step(2);
   endtask
   task cmp(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task chk(input logic [5:0] e);
      q.push_back(e);
      ->smp;
   endtask
   task done;
      tn++;
      $display("test %0d done", tn);
   endtask
   task per(output int c);
      c = 0;
      while (baud_tick !== 1'b1) step(1);
      do
      begin
         step(1);
         c++;
      end while (baud_tick !== 1'b1);
   endtask
   task end_of_test;
      $display("checks=%0d mismatches=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Monitor takes the oldest expected code when a sample is due
   always @(smp)
   begin : mon
      logic [5:0] e;
      e = q.pop_front();
      cmp({irq, pending_source_id_reg}, {e != uib_pkg::ID_NONE, e});
   end
   initial
   begin
      #100us;
      err_count++;
      end_of_test;
   end
   initial
   begin
      clk = 1'b0;
      nrst = 1'b0;
      line_idle = 1'b1;
      {source_enable_reg, line_control_reg, modem_control_reg,
       divisor_low_byte, divisor_high_byte, divisor_fraction_reg,
       modem_change_flags, fifo_enable, rx_fifo_nonempty, rx_data_available,
       rx_above_trigger, rx_fifo_error_any, head_framing_flag,
       head_parity_flag, head_break_flag, overrun_event, rx_char_event,
       tx_holding_empty, tx_passed_trigger, tx_serial_in, flow_off_event,
       special_char_event, flow_on_event, rts_pin, cts_pin,
       receive_holding_read, transmit_holding_write, ident_read,
       line_state_read, modem_state_read} = '0;
      void'($urandom(95));
      step(16);
      nrst = 1'b1;
      step(2);
      chk(uib_pkg::ID_NONE);
      cmp({line_err_flags, line_overrun, timeout_pending}, 16'h0000);
      done;
      rx_data_available = 1'b1;
      tx_holding_empty = 1'b1;
      modem_change_flags = 4'h1;
      step(3);
      chk(uib_pkg::ID_NONE);
      source_enable_reg = 8'hFF;
      step(2);
      chk(uib_pkg::ID_RXDATA);
      rx_fifo_error_any = 1'b1;
      step(2);
      chk(uib_pkg::ID_LINE);
      rx_fifo_error_any = 1'b0;
      rx_data_available = 1'b0;
      step(2);
      chk(uib_pkg::ID_TX);
      tx_holding_empty = 1'b0;
      pulse(ident_read);
      chk(uib_pkg::ID_MODEM);
      modem_change_flags = 4'h0;
      step(2);
      chk(uib_pkg::ID_NONE);
      done;
      fifo_enable = 1'b1;
      rx_above_trigger = 1'b1;
      step(2);
      chk(uib_pkg::ID_RXDATA);
      rx_above_trigger = 1'b0;
      tx_passed_trigger = 1'b1;
      step(2);
      chk(uib_pkg::ID_TX);
      tx_passed_trigger = 1'b0;
      pulse(transmit_holding_write);
      chk(uib_pkg::ID_NONE);
      pulse(overrun_event);
      chk(uib_pkg::ID_LINE);
      pulse(line_state_read);
      chk(uib_pkg::ID_NONE);
      done;
      pulse(flow_off_event);
      chk(uib_pkg::ID_FLOWOFF);
      pulse(ident_read);
      chk(uib_pkg::ID_FLOWOFF);
      pulse(flow_on_event);
      chk(uib_pkg::ID_NONE);
      pulse(special_char_event);
      pulse(ident_read);
      chk(uib_pkg::ID_NONE);
      source_enable_reg = 8'hDF;
      pulse(flow_off_event);
      chk(uib_pkg::ID_NONE);
      pulse(flow_on_event);
      source_enable_reg = 8'hFF;
      cts_pin = 1'b1;
      step(3);
      chk(uib_pkg::ID_HSHAKE);
      pulse(ident_read);
      chk(uib_pkg::ID_NONE);
      done;
      line_idle = 1'b0;
      rx_fifo_nonempty = 1'b1;
      r = 3'($urandom);
      {head_break_flag, head_framing_flag, head_parity_flag} = r;
      step(2);
      cmp(line_err_flags, r);
      rx_fifo_nonempty = 1'b0;
      step(2);
      cmp(line_err_flags, 3'h0);
      for (int i = 0; i < 4; i++)
      begin
         tx_serial_in = 1'($urandom);
         line_control_reg[6] = i[0];
         step(1);
         cmp(tx_serial_out, tx_serial_in & !i[0]);
      end
      line_control_reg = 8'h00;
      done;
      source_enable_reg = 8'h00;
      n = 0;
      repeat (40)
      begin
         step(1);
         n += baud_tick;
      end
      cmp(n, 0);
      d = 2 + $urandom % 8;
      divisor_low_byte = 8'(d);
      per(p);
      per(p);
      cmp(p, d);
      divisor_fraction_reg = 8'h20;
      per(p);
      per(p);
      per(p2);
      cmp(p + p2, 2 * d + 1);
      divisor_fraction_reg = 8'h00;
      modem_control_reg = 8'h80;
      per(p);
      per(p);
      cmp(p, 4 * d);
      modem_control_reg = 8'h00;
      done;
      divisor_low_byte = 8'h01;
      divisor_fraction_reg = 8'h80;
      source_enable_reg = 8'h01;
      {head_break_flag, head_framing_flag, head_parity_flag} = 3'h0;
      line_idle = 1'b1;
      rx_fifo_nonempty = 1'b1;
      pulse(rx_char_event);
      step(240);
      cmp(timeout_pending, 1'b0);
      step(40);
      cmp(timeout_pending, 1'b1);
      chk(uib_pkg::ID_TIMEOUT);
      pulse(receive_holding_read);
      cmp(timeout_pending, 1'b0);
      done;
      end_of_test;
   end
endmodule
